/* hw/ppg_regs.vh */
`ifndef PPG_REGS_VH
`define PPG_REGS_VH
// ==========================================
// i/o address map
`define PPG_ADDR_G1_A 8'he4
`define PPG_ADDR_G1_B 8'he5
`define PPG_ADDR_G1_C 8'he6
`define PPG_ADDR_G2_A 8'he8
`define PPG_ADDR_G2_B 8'he9
`define PPG_ADDR_G2_C 8'hea
`define PPG_ADDR_G2_CTL 8'heb
// ==========================================
// control word fields
`define PPG_CW_SET 7
`define PPG_CW_A_IN 4
`define PPG_CW_CU_IN 3
`define PPG_CW_B_MODE 2
`define PPG_CW_B_IN 1
`define PPG_CW_CL_IN 0
// ==========================================
// reset values
`define PPG_DIR_IN_ALL 8'h00
`define PPG_LATCH_RST 8'h00
`define PPG_RD_IDLE 8'h00
`endif

/* hw/ppg_pin_port.v */
`timescale 1ns/100ps
`include "ppg_regs.vh"
// one 8-bit port: output latch, pin synchroniser, per-bit direction
module ppg_pin_port
(
   input wire clk,
   input wire nrst,
   input wire wrStb,
   input wire [7:0] wrData,
   input wire [7:0] dirOut,
   input wire [7:0] pinIn,
   output reg [7:0] pinOut,
   output reg [7:0] pinOe,
   output reg [7:0] rdValue
);
   reg [7:0] latch;
   reg [7:0] syncA;
   reg [7:0] syncB;
   // ==========================================
   // latch, synchroniser and pin drive
   always @(posedge clk)
   begin
      if (!nrst)
      begin
         latch <= `PPG_LATCH_RST;
         syncA <= `PPG_LATCH_RST;
         syncB <= `PPG_LATCH_RST;
         pinOut <= `PPG_LATCH_RST;
         pinOe <= `PPG_DIR_IN_ALL;
         rdValue <= `PPG_LATCH_RST;
      end
      else
      begin
         if (wrStb)
            latch <= wrData; // holds until next write
         syncA <= pinIn;
         syncB <= syncA;
         pinOut <= wrStb ? wrData : latch;
         pinOe <= dirOut;
         // output bits read back the latch, input bits the pins
         rdValue <= (dirOut & latch) | (~dirOut & syncB);
      end
   end
endmodule // ppg_pin_port

/* hw/ppg_group_two.v */
`timescale 1ns/100ps
`include "ppg_regs.vh"
module ppg_group_two
(
   input wire clk,
   input wire nrst,
   input wire [7:0] ioAddr,
   input wire [7:0] ioWrData,
   input wire ioWr,
   input wire ioRd,
   output reg [7:0] ioRdData,
   output reg ioRdValid,
   output reg groupOneSel,
   input wire [7:0] portAIn,
   output wire [7:0] portAOut,
   output wire [7:0] portAOe,
   input wire [7:0] portBIn,
   output wire [7:0] portBOut,
   output wire [7:0] portBOe,
   input wire [7:0] portCIn,
   output wire [7:0] portCOut,
   output wire [7:0] portCOe
);

   // ==========================================
   // direction and read state
   reg [7:0] dirA; // high bits drive port a pins
   reg [7:0] dirB; // high bits drive port b pins
   reg [7:0] dirC; // upper and lower halves set apart
   reg [7:0] next_dirA;
   reg [7:0] next_dirB;
   reg [7:0] next_dirC;
   reg [7:0] next_ioRdData;
   reg next_ioRdValid;
   reg next_groupOneSel;
   // read values as each port presents them
   wire [7:0] rdA;
   wire [7:0] rdB;
   wire [7:0] rdC;
   // decoded strobes and hits
   wire wrA;
   wire wrB;
   wire wrC;
   wire wrCtl;
   wire g1Hit;
   wire g2Hit;
   // control word fields, 1 means input
   wire cwAIn;
   wire cwBIn;
   wire cwCUIn;
   wire cwCLIn;

   // ==========================================
   // address decode
   // write strobes, one per data address of this group
   assign wrA = ioWr && (ioAddr == `PPG_ADDR_G2_A);
   assign wrB = ioWr && (ioAddr == `PPG_ADDR_G2_B);
   assign wrC = ioWr && (ioAddr == `PPG_ADDR_G2_C);
   // a control write without the set bit changes nothing
   assign wrCtl = ioWr && (ioAddr == `PPG_ADDR_G2_CTL) && ioWrData[`PPG_CW_SET];
   // first group lives outside this block; only flag the access
   assign g1Hit = (ioAddr == `PPG_ADDR_G1_A) ||
                  (ioAddr == `PPG_ADDR_G1_B) ||
                  (ioAddr == `PPG_ADDR_G1_C);
   // data addresses of this group that answer a read
   assign g2Hit = (ioAddr == `PPG_ADDR_G2_A) ||
                  (ioAddr == `PPG_ADDR_G2_B) ||
                  (ioAddr == `PPG_ADDR_G2_C);

   // ==========================================
   // control word fields
   // each field is 1 for input; the drive enable is its inverse
   assign cwAIn = ioWrData[`PPG_CW_A_IN];
   assign cwBIn = ioWrData[`PPG_CW_B_IN];
   assign cwCUIn = ioWrData[`PPG_CW_CU_IN];
   assign cwCLIn = ioWrData[`PPG_CW_CL_IN];
   // the mode select bit is not decoded: only mode 0 exists here

   // ==========================================
   // next directions
   // every field comes from the same word, so all ports move together
   always @*
   begin
      next_dirA = dirA;
      next_dirB = dirB;
      next_dirC = dirC;
      if (wrCtl)
      begin
         next_dirA = {8{~cwAIn}};
         next_dirB = {8{~cwBIn}};
         // upper and lower halves of c follow their own bits
         next_dirC = {{4{~cwCUIn}}, {4{~cwCLIn}}};
      end
   end

   // ==========================================
   // direction registers
   // reset leaves every pin undriven so nothing fights the far side
   always @(posedge clk)
   begin
      if (!nrst)
      begin
         dirA <= `PPG_DIR_IN_ALL;
         dirB <= `PPG_DIR_IN_ALL;
         dirC <= `PPG_DIR_IN_ALL;
      end
      else
      begin
         dirA <= next_dirA;
         dirB <= next_dirB;
         // both bits set: all in; both clear: all out
         dirC <= next_dirC;
      end
   end

   // ==========================================
   // the three ports
   // port a: one direction for all eight bits
   ppg_pin_port uPortA
   (
      .clk(clk),
      .nrst(nrst),
      .wrStb(wrA),
      .wrData(ioWrData),
      .dirOut(dirA),
      .pinIn(portAIn),
      .pinOut(portAOut),
      .pinOe(portAOe),
      .rdValue(rdA)
   );
   // port b: one direction for all eight bits
   ppg_pin_port uPortB
   (
      .clk(clk),
      .nrst(nrst),
      .wrStb(wrB),
      .wrData(ioWrData),
      .dirOut(dirB),
      .pinIn(portBIn),
      .pinOut(portBOut),
      .pinOe(portBOe),
      .rdValue(rdB)
   );
   // port c: per-bit directions allow the split halves
   ppg_pin_port uPortC
   (
      .clk(clk),
      .nrst(nrst),
      .wrStb(wrC),
      .wrData(ioWrData),
      .dirOut(dirC),
      .pinIn(portCIn),
      .pinOut(portCOut),
      .pinOe(portCOe),
      .rdValue(rdC)
   );

   // ==========================================
   // read mux
   // control word is write only and reads zero, as do foreign addresses
   always @*
   begin
      next_ioRdData = `PPG_RD_IDLE;
      next_ioRdValid = 1'b0;
      next_groupOneSel = (ioRd || ioWr) && g1Hit;
      if (ioRd)
      begin
         next_ioRdValid = g2Hit;
         case (ioAddr)
            `PPG_ADDR_G2_A: next_ioRdData = rdA;
            `PPG_ADDR_G2_B: next_ioRdData = rdB;
            `PPG_ADDR_G2_C: next_ioRdData = rdC;
            default: next_ioRdData = `PPG_RD_IDLE;
         endcase
      end
   end

   // ==========================================
   // read registers
   // data stands one cycle per read strobe, zero otherwise
   always @(posedge clk)
   begin
      if (!nrst)
      begin
         ioRdData <= `PPG_RD_IDLE;
         ioRdValid <= 1'b0;
         groupOneSel <= 1'b0;
      end
      else
      begin
         ioRdData <= next_ioRdData;
         ioRdValid <= next_ioRdValid;
         groupOneSel <= next_groupOneSel;
      end
   end
endmodule // ppg_group_two

/* test/ppg_group_two_props.sv */
`timescale 1ns/100ps
// ==========
// port checker
module ppg_group_two_props(input wire clk,nrst,ioWr,ioRd,ioRdValid,groupOneSel,
   input wire [7:0] ioAddr,ioWrData,portAOe,portBOe,portCOe,portCOut);
   default clocking @(posedge clk); endclocking
   default disable iff (!nrst);
   // control word write strobe
   wire cw = ioWr && ioAddr==8'heb;
   chk_reset_dirs: assert property($rose(nrst)|->!(portAOe|portBOe|portCOe))
      else $error("rst");
   chk_ignored_cw: assert property(cw&&!ioWrData[7]|->##2 $stable({portAOe,portBOe,portCOe}))
      else $error("cw");
   chk_a_dir: assert property(cw&&ioWrData[7]|->##2 portAOe=={8{!$past(ioWrData[4],2)}})
      else $error("a");
   chk_b_dir: assert property(cw&&ioWrData[7]|->##2 portBOe=={8{!$past(ioWrData[1],2)}})
      else $error("b");
   chk_c_dir: assert property(cw&&ioWrData[7]|->##2 portCOe==
      {{4{!$past(ioWrData[3],2)}},{4{!$past(ioWrData[0],2)}}})else $error("c");
   chk_c_latch: assert property(ioWr&&ioAddr==8'hea|=>portCOut==$past(ioWrData))
      else $error("latch");
   chk_rd_valid: assert property(ioRd&&ioAddr>=8'he8&&ioAddr<=8'hea|=>ioRdValid)
      else $error("valid");
   chk_group_one: assert property((ioRd||ioWr)&&ioAddr>=8'he4&&ioAddr<=8'he6
      |=>groupOneSel) else $error("grp");
endmodule // ppg_group_two_props
bind ppg_group_two ppg_group_two_props ppg_group_two_props_i(.*);

/* test/ppg_pin_model.sv */
`timescale 1ns/100ps
// ==========
// far-side device: owns every pin the port leaves undriven
module ppg_pin_model(input wire [7:0] oe,out,drv,output wire [7:0] pin);
   assign pin = (oe&out)|(~oe&drv);
endmodule // ppg_pin_model

/* test/ppg_group_two_tb.sv */
`timescale 1ns/100ps
// ==========
// bench top
module ppg_group_two_tb;
   reg clk=0,nrst=0,ioWr=0,ioRd=0;
   reg [7:0] ioAddr=0,ioWrData=0,s=8'h17,c,lat[3],drv[3]='{0,0,0},oe[3]='{0,0,0};
   reg [7:0] tbl[5]='{8'h80,8'h9b,8'h88,8'h81,8'h12};
   wire [7:0] rdD,aO,aE,bO,bE,cO,cE,aI,bI,cI;
   integer err_count=0,n_compared=0,cyc=0,k,p;
   ppg_group_two ppg_group_two_i(.clk,.nrst,.ioAddr,.ioWrData,.ioWr,.ioRd,.ioRdData(rdD),
      .ioRdValid(),.groupOneSel(),.portAIn(aI),.portAOut(aO),.portAOe(aE),.portBIn(bI),
      .portBOut(bO),.portBOe(bE),.portCIn(cI),.portCOut(cO),.portCOe(cE));
   ppg_pin_model ppg_pin_model_i[2:0](.oe({cE,bE,aE}),.out({cO,bO,aO}),
      .drv({drv[2],drv[1],drv[0]}),.pin({cI,bI,aI}));
   initial forever #2 clk=~clk;
   // hang guard
   always @(posedge clk)
   begin
      cyc=cyc+1;
      if(cyc>2000) begin err_count=err_count+1; finish_test; end
   end
   function [7:0] lf(input [7:0] v); lf={v[6:0],v[7]^v[5]^v[4]^v[3]}; endfunction
   task chk(input [23:0] seen,exp);
      n_compared=n_compared+1;
      if(seen!==exp) begin err_count=err_count+1; $display("[ERR] %0t %h %h",$time,seen,exp); end
   endtask
   task wr(input [7:0] a,d);
      @(posedge clk); ioAddr<=a; ioWrData<=d; ioWr<=1;
      @(posedge clk); ioWr<=0;
   endtask
   task rd(input [7:0] a,e);
      @(posedge clk); ioAddr<=a; ioRd<=1;
      @(posedge clk); ioRd<=0;
      @(negedge clk); chk(rdD,e);
   endtask
   task finish_test;
      if(err_count==0 && n_compared>0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask
   // ==========
   // direction table walk, last word has no set bit and must be ignored
   initial
   begin
      repeat(8) @(posedge clk);
      nrst<=1;
      @(negedge clk); chk({aE,bE,cE},0);
      for(k=0;k<5;k=k+1)
      begin
         c=tbl[k];
         if(c[7]) begin oe[0]={8{!c[4]}}; oe[1]={8{!c[1]}}; oe[2]={{4{!c[3]}},{4{!c[0]}}}; end
         for(p=0;p<3;p=p+1) begin s=lf(s); drv[p]<=s; s=lf(s); lat[p]=s; wr(8'he8+p,s); end
         wr(8'heb,c);
         repeat(6) @(posedge clk);
         for(p=0;p<3;p=p+1) rd(8'he8+p,(lat[p]&oe[p])|(drv[p]&~oe[p]));
         chk({aE,bE,cE},{oe[0],oe[1],oe[2]});
         chk({aO,bO,cO},{lat[0],lat[1],lat[2]});
      end
      rd(8'he4,0);
      rd(8'heb,0);
      finish_test;
   end
endmodule // ppg_group_two_tb
